// *** rtl/roc_pkg.sv ***
// Shared constants and types of the option and state control block
package roc_pkg;

	// Opcodes (instruction bits 0-7, held in op_instr_i[15:8])
	localparam logic [7:0] OPC_SEM_CLR = 8'h12;
	localparam logic [7:0] OPC_SEM_TST = 8'h11;
	localparam logic [7:0] OPC_BRANCH = 8'hef;
	localparam logic [7:0] OPC_XSTATE = 8'hfe;
	localparam logic [7:0] OPC_OPTION = 8'hfd;
	localparam logic [7:0] OPC_XREG_WR = 8'hfc;

	// Address word fields (word bits 16-31 held in [15:0])
	localparam int ADR_GRP_LSB = 8;
	localparam int ADR_EXT_BIT = 8;
	localparam int ADR_ST_LSB = 5;
	localparam int ADR_REG_LSB = 0;

	// Option groups and registers
	localparam logic [3:0] GRP_BOUNDS = 4'h5;
	localparam logic [3:0] GRP_ACCT = 4'h6;
	localparam logic [4:0] ACCT_WORD1 = 5'h01;
	localparam logic [2:0] FIRST_GP_STATE = 3'h5;
	localparam logic [15:0] BOUND_OFF = 16'hff00;
	localparam logic [15:0] BOUND_RST = 16'hff00;

	// Processor states and registers
	localparam logic [2:0] EXEC_STATE = 3'h4;
	localparam logic [3:0] XS_SEL_REG = 4'h8;
	localparam logic [4:0] EXT_LAST_REG = 5'h0f;
	localparam logic [4:0] EXT_IO_FIRST = 5'h0c;
	localparam logic [2:0] IO_LAST_STATE = 3'h3;
	localparam logic [15:0] XS_SEL_RST = 16'h0000;

	// Semaphore
	localparam logic [3:0] SEM_OPEN_BIT = 4'hf;
	localparam logic [15:0] SEM_RST = 16'h0000;

	// Program address advance in bytes
	localparam logic [2:0] ADV_TAKEN = 3'h6;
	localparam logic [2:0] ADV_FALL = 3'h2;

	// One result travelling down the two-stage pipe
	typedef struct packed {
		logic valid;
		logic invalid;
		logic wb;
		logic to_mem;
		logic [2:0] wreg;
		logic [15:0] data;
		logic [2:0] adv;
		logic cm;
		logic [15:0] cm_addr;
		logic [2:0] cm_param;
		logic acct;
		logic acct_lo;
	} roc_res_s;

endpackage

// *** rtl/roc_cnt_if.sv ***
// Carrier between the control logic and the slot counter store
interface roc_cnt_if;
	logic inc;
	logic [2:0] inc_idx;
	logic clr;
	logic [2:0] clr_idx;
	logic [2:0] rd_idx;
	logic [31:0] rd_data;

	modport ctl (output inc, inc_idx, clr, clr_idx, rd_idx, input rd_data);
	modport mem (input inc, inc_idx, clr, clr_idx, rd_idx, output rd_data);
endinterface

// *** rtl/roc_cnt_mem.sv ***
// Eight slot grant counters with a registered read port
module roc_cnt_mem (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Counter access
	roc_cnt_if.mem port
);
	import roc_pkg::*;

	logic [7:0][31:0] cnt_q;
	logic [31:0] rd_q;

	////////////////////////////////////////////////////////////////
	// Counters: an increment in the clearing cycle is kept as 1
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_q <= '0;
		end else begin
			for (int i = 0; i < 8; i++) begin
				if (port.clr && port.clr_idx == 3'(i)) begin
					cnt_q[i] <= {31'h0, port.inc && port.inc_idx == 3'(i)};
				end else if (port.inc && port.inc_idx == 3'(i)) begin
					cnt_q[i] <= cnt_q[i] + 32'h1;
				end
			end
		end
	end

	// Registered read data
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rd_q <= 32'h0;
		end else begin
			rd_q <= cnt_q[port.rd_idx];
		end
	end

	assign port.rd_data = rd_q;

	////////////////////////////////////////////////////////////////
	// Checking helpers
	logic chk_live_q;
	logic [2:0] chk_idx_q;
	logic [31:0] chk_val_q;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			chk_live_q <= 1'b0;
			chk_idx_q <= 3'h0;
			chk_val_q <= 32'h0;
		end else begin
			chk_live_q <= port.inc && !(port.clr && port.clr_idx == port.inc_idx);
			chk_idx_q <= port.inc_idx;
			chk_val_q <= cnt_q[port.inc_idx] + 32'h1;
		end
	end

	chk_cnt_step: assert property (@(posedge clk_i) disable iff (!resetn_i)
		chk_live_q |-> cnt_q[chk_idx_q] == chk_val_q)
		else $error("slot counter did not advance by one");

endmodule

// *** rtl/roc_ctl.sv ***
// Option registers, semaphore, cross-state read and control-memory branch
import roc_pkg::*;

// Behaviour
// - Privileged state loads cross-state select via extended write, register 08.
// - Only the executive state performs a cross-state access.
// - Unprivileged option read or write posts invalid-instruction, no access.
// - Groups 3, 4, 5, 8-F have one register, number 0.
// - Read of a missing option feature returns all zeros.
// - Write to a missing option feature does nothing, raises no flag.
// - Bounds checked on storage writes of states 5, 6, 7 only.
// - Bound register: upper page high byte, lower page low byte.
// - Bound value FF00 disables checking for that state.
// - Each state's 32-bit counter counts its granted major cycles.
// - Counters read-only; a write clears the counter.
// - Opcode 12 clears one semaphore bit named by bits 8-11.
// - Semaphore ops need privilege unless they name bit 15.
// - Opcode 11 sets a clear bit, advance 6; else advance 2.
// - Cross-state read by state 4; not extended I/O of states 0-3.
// - Bit 8 is 0 for the cross-state read.
// - Target address is immediate word plus optional index register.
// - Bit 23 file, bits 24-26 state, bits 27-31 register.
// - Bits 16-22 of the cross-state word are ignored.
// - Privileged branch to R1 address, 3-bit parameter from bits 13-15.
// - Cross-state read result goes to R2 or memory if indirect.
// - Option word: bits 20-23 group, 24-26 state, 27-31 register.
module roc_ctl (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Instruction issue
	input wire logic op_valid_i,
	input wire logic [2:0] op_state_i,
	input wire logic [15:0] op_instr_i,
	input wire logic [15:0] op_word_i,
	input wire logic [15:0] op_reg1_i,
	input wire logic [15:0] op_reg2_i,
	input wire logic [7:0] priv_mode_i,
	// Slot grants
	input wire logic grant_valid_i,
	input wire logic [2:0] grant_state_i,
	// Main storage write check
	input wire logic mem_wr_i,
	input wire logic [2:0] mem_wr_state_i,
	input wire logic [15:0] mem_wr_addr_i,
	output logic mem_wr_ok_o,
	// Cross-state file read
	output logic xs_rd_o,
	output logic xs_ext_o,
	output logic [2:0] xs_state_o,
	output logic [4:0] xs_reg_o,
	input wire logic [15:0] xs_data_i,
	// Results
	output logic done_o,
	output logic invalid_o,
	output logic wb_valid_o,
	output logic wb_to_mem_o,
	output logic [2:0] wb_reg_o,
	output logic [15:0] wb_data_o,
	output logic [2:0] pa_adv_o,
	output logic cm_branch_o,
	output logic [15:0] cm_addr_o,
	output logic [2:0] cm_param_o,
	// Visible state
	output logic [15:0] sem_o,
	output logic [15:0] xs_select_o
);
	import roc_pkg::*;

	// Bound register slot of a general-purpose state
	function automatic logic [1:0] bound_slot(input logic [2:0] st);
		bound_slot = 2'(st - FIRST_GP_STATE);
	endfunction

	// True for a general-purpose state
	function automatic logic is_gp(input logic [2:0] st);
		is_gp = st >= FIRST_GP_STATE;
	endfunction

	////////////////////////////////////////////////////////////////
	// Storage
	logic [2:0][15:0] bound_q;
	logic [2:0][15:0] bound_d;
	logic [15:0] sem_q;
	logic [15:0] sem_d;
	logic [15:0] xs_sel_q;
	logic [15:0] xs_sel_d;
	roc_res_s res1_q;
	roc_res_s res1_d;
	roc_res_s res2_q;
	roc_res_s res2_d;

	roc_cnt_if cnt_if ();

	////////////////////////////////////////////////////////////////
	// Instruction fields
	logic [7:0] opc;
	logic fx_bit;
	logic [2:0] r1_fld;
	logic ind_bit;
	logic [2:0] r2_fld;
	logic [3:0] sem_bit;
	logic priv;
	logic is_exec;

	assign opc = op_instr_i[15:8];
	assign fx_bit = op_instr_i[7];
	assign r1_fld = op_instr_i[6:4];
	assign ind_bit = op_instr_i[3];
	assign r2_fld = op_instr_i[2:0];
	assign sem_bit = op_instr_i[7:4];
	assign priv = priv_mode_i[op_state_i];
	assign is_exec = op_state_i == EXEC_STATE;

	// Operation select
	logic do_clr;
	logic do_tst;
	logic do_bcm;
	logic do_xs;
	logic do_opt;
	logic do_xwr;

	assign do_clr = op_valid_i && opc == OPC_SEM_CLR;
	assign do_tst = op_valid_i && opc == OPC_SEM_TST;
	assign do_bcm = op_valid_i && opc == OPC_BRANCH;
	assign do_xs = op_valid_i && opc == OPC_XSTATE && !fx_bit;
	assign do_opt = op_valid_i && opc == OPC_OPTION;
	assign do_xwr = op_valid_i && opc == OPC_XREG_WR && op_instr_i[3:0] == XS_SEL_REG;

	////////////////////////////////////////////////////////////////
	// Effective address: an R1 field of zero means no index
	logic [15:0] eff;

	assign eff = op_word_i + (r1_fld != 3'h0 ? op_reg1_i : 16'h0);

	// Address word fields; bits 16-22 of the cross-state word fall outside
	logic [3:0] a_grp;
	logic [2:0] a_st;
	logic [4:0] a_reg;
	logic a_ext;

	assign a_grp = eff[ADR_GRP_LSB +: 4];
	assign a_st = eff[ADR_ST_LSB +: 3];
	assign a_reg = eff[ADR_REG_LSB +: 5];
	assign a_ext = eff[ADR_EXT_BIT];

	////////////////////////////////////////////////////////////////
	// Option feature decode; bounds only exist at register 0
	logic bnd_hit;
	logic acct_hit;
	logic opt_ok;

	assign bnd_hit = a_grp == GRP_BOUNDS && is_gp(a_st) && a_reg == 5'h00;
	assign acct_hit = a_grp == GRP_ACCT && a_reg <= ACCT_WORD1;
	assign opt_ok = do_opt && priv;

	// Cross-state legality
	logic xs_io;
	logic xs_bad;
	logic xs_go;

	assign xs_io = a_ext && a_st <= IO_LAST_STATE && a_reg >= EXT_IO_FIRST;
	assign xs_bad = xs_io || (a_ext && a_reg > EXT_LAST_REG);
	assign xs_go = do_xs && is_exec && !xs_bad;

	// Semaphore privilege, waived for the open bit
	logic sem_ok;

	assign sem_ok = priv || sem_bit == SEM_OPEN_BIT;

	////////////////////////////////////////////////////////////////
	// Bounds write; a missing feature is silently dropped
	always_comb begin
		bound_d = bound_q;
		if (opt_ok && fx_bit && bnd_hit) begin
			bound_d[bound_slot(a_st)] = op_reg2_i;
		end
	end

	// Counter store hookup; software writes only ever clear
	assign cnt_if.inc = grant_valid_i;
	assign cnt_if.inc_idx = grant_state_i;
	assign cnt_if.clr = opt_ok && fx_bit && acct_hit;
	assign cnt_if.clr_idx = a_st;
	assign cnt_if.rd_idx = a_st;

	roc_cnt_mem u_cnt (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.port(cnt_if.mem)
	);

	////////////////////////////////////////////////////////////////
	// Semaphore update is done in the issue cycle, so test-and-set is atomic
	always_comb begin
		sem_d = sem_q;
		if (do_clr && sem_ok) begin
			sem_d[sem_bit] = 1'b0;
		end
		if (do_tst && sem_ok) begin
			sem_d[sem_bit] = 1'b1;
		end
	end

	// Select register: extended write or the automatic load by a read
	always_comb begin
		xs_sel_d = xs_sel_q;
		if (do_xwr && priv) begin
			xs_sel_d = op_reg2_i;
		end else if (xs_go) begin
			xs_sel_d = eff;
		end
	end

	////////////////////////////////////////////////////////////////
	// First stage result
	always_comb begin
		res1_d = '0;
		res1_d.valid = do_clr || do_tst || do_bcm || do_xs || do_opt || do_xwr;
		res1_d.to_mem = ind_bit;
		res1_d.wreg = r2_fld;
		res1_d.cm_addr = op_reg1_i;
		res1_d.cm_param = op_instr_i[2:0];
		res1_d.acct_lo = a_reg[0];
		res1_d.adv = sem_q[sem_bit] ? ADV_FALL : ADV_TAKEN;
		if (do_opt) begin
			res1_d.invalid = !priv;
			res1_d.wb = priv && !fx_bit;
			res1_d.acct = acct_hit;
			res1_d.data = bnd_hit ? bound_q[bound_slot(a_st)] : 16'h0;
		end
		if (do_xs) begin
			res1_d.invalid = !xs_go;
			res1_d.wb = xs_go;
			res1_d.data = xs_data_i;
		end
		if (do_clr || do_tst) begin
			res1_d.invalid = !sem_ok;
		end
		if (do_xwr) begin
			res1_d.invalid = !priv;
		end
		if (do_bcm) begin
			res1_d.invalid = !priv;
			res1_d.cm = priv;
		end
		if (!(do_tst && sem_ok)) begin
			res1_d.adv = 3'h0;
		end
	end

	// Second stage picks the counter half: word 0 is the high half
	always_comb begin
		res2_d = res1_q;
		if (res1_q.acct) begin
			res2_d.data = res1_q.acct_lo ? cnt_if.rd_data[15:0] : cnt_if.rd_data[31:16];
		end
	end

	////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bound_q <= {3{BOUND_RST}};
			sem_q <= SEM_RST;
			xs_sel_q <= XS_SEL_RST;
			res1_q <= '0;
			res2_q <= '0;
		end else begin
			bound_q <= bound_d;
			sem_q <= sem_d;
			xs_sel_q <= xs_sel_d;
			res1_q <= res1_d;
			res2_q <= res2_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Bounds check on storage writes; reads never reach it
	logic [15:0] wr_bound;
	logic [7:0] wr_page;
	logic wr_in;

	assign wr_bound = is_gp(mem_wr_state_i) ? bound_q[bound_slot(mem_wr_state_i)] : BOUND_OFF;
	assign wr_page = mem_wr_addr_i[15:8];
	assign wr_in = wr_page >= wr_bound[7:0] && wr_page <= wr_bound[15:8];
	assign mem_wr_ok_o = !mem_wr_i || !is_gp(mem_wr_state_i)
		|| wr_bound == BOUND_OFF || wr_in;

	// Cross-state request to the register files
	assign xs_rd_o = xs_go;
	assign xs_ext_o = a_ext;
	assign xs_state_o = a_st;
	assign xs_reg_o = a_reg;

	// Result outputs
	assign done_o = res2_q.valid;
	assign invalid_o = res2_q.invalid;
	assign wb_valid_o = res2_q.wb;
	assign wb_to_mem_o = res2_q.to_mem;
	assign wb_reg_o = res2_q.wreg;
	assign wb_data_o = res2_q.data;
	assign pa_adv_o = res2_q.adv;
	assign cm_branch_o = res2_q.cm;
	assign cm_addr_o = res2_q.cm_addr;
	assign cm_param_o = res2_q.cm_param;
	assign sem_o = sem_q;
	assign xs_select_o = xs_sel_q;

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	sequence s_tst_free;
		do_tst && sem_ok && !sem_q[sem_bit];
	endsequence

	sequence s_tst_reply;
		done_o && pa_adv_o == ADV_TAKEN && !invalid_o;
	endsequence

	chk_opt_unpriv_invalid: assert property (
		do_opt && !priv |-> ##2 done_o && invalid_o && !wb_valid_o)
		else $error("unprivileged option access not flagged");

	chk_absent_read_zero: assert property (
		opt_ok && !fx_bit && !bnd_hit && !acct_hit |-> ##2 wb_data_o == 16'h0)
		else $error("missing option feature read not zero");

	chk_absent_write_nop: assert property (
		opt_ok && fx_bit && !bnd_hit && !acct_hit |=> $stable(bound_q) ##1 !invalid_o)
		else $error("missing option feature write had an effect");

	chk_bound_disable: assert property (
		mem_wr_i && wr_bound == BOUND_OFF |-> mem_wr_ok_o)
		else $error("disabled bound blocked a write");

	chk_bound_states: assert property (
		!mem_wr_ok_o |-> mem_wr_i && mem_wr_state_i >= 3'h5)
		else $error("write blocked outside states 5 to 7");

	chk_tst_free_set: assert property (
		s_tst_free |=> sem_q[$past(sem_bit)] ##1 s_tst_reply)
		else $error("test-and-set on clear bit misbehaved");

	chk_tst_busy_keep: assert property (
		do_tst && sem_ok && sem_q[sem_bit] |=> $stable(sem_q) ##1 pa_adv_o == ADV_FALL)
		else $error("test-and-set on set bit misbehaved");

	chk_clr_one_bit: assert property (
		do_clr && sem_ok |=> !sem_q[$past(sem_bit)])
		else $error("semaphore clear missed its bit");

	chk_xs_exec_only: assert property (
		xs_rd_o |-> op_state_i == 3'h4 && !op_instr_i[7])
		else $error("cross-state read outside executive state");

	chk_bcm_target: assert property (
		do_bcm && priv |-> ##2 cm_branch_o && cm_addr_o == $past(op_reg1_i, 2))
		else $error("control memory branch address wrong");

endmodule

// *** testbench/roc_far_model.sv ***
// Far side model: register files of the eight states behind the cross-state read port
module roc_far_model (
	// Clock
	input wire logic clk_i,
	// Cross-state file read
	input wire logic xs_rd_i,
	input wire logic xs_ext_i,
	input wire logic [2:0] xs_state_i,
	input wire logic [4:0] xs_reg_i,
	output logic [15:0] xs_data_o
);
	logic [15:0] noise_q = 16'h5a3c;

	// Between reads the port shows a pattern that changes every cycle, never a stale word
	always_ff @(posedge clk_i) begin
		noise_q <= {noise_q[14:0], noise_q[15] ^ noise_q[13]};
	end

	// Each file, state and register holds its own recognisable word
	assign xs_data_o = xs_rd_i ? {xs_ext_i, xs_state_i, xs_reg_i, 7'h35} ^ 16'h9c00 : noise_q;
endmodule

// *** testbench/register_option_and_state_control_tb.sv ***
// Self-checking bench of the option and state control block
module register_option_and_state_control_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import roc_pkg::*;

	logic clk_i = 0;
	logic resetn_i = 0;
	logic op_valid_i = 0, grant_valid_i = 0, mem_wr_i = 0;
	logic [2:0] op_state_i = 0, grant_state_i = 0, mem_wr_state_i = 0;
	logic [15:0] op_instr_i = 0, op_word_i = 0, op_reg1_i = 0, op_reg2_i = 0;
	logic [15:0] mem_wr_addr_i = 0;
	logic [15:0] xs_data_i;
	logic [7:0] priv_mode_i = 8'hff;
	logic mem_wr_ok_o, xs_rd_o, xs_ext_o, done_o, invalid_o, wb_valid_o, wb_to_mem_o;
	logic cm_branch_o;
	logic [2:0] xs_state_o, wb_reg_o, pa_adv_o, cm_param_o;
	logic [4:0] xs_reg_o;
	logic [15:0] wb_data_o, cm_addr_o, sem_o, xs_select_o;
	int failures = 0;
	int n_tests = 0;
	int cyc = 0;
	int b, s;
	logic [31:0] cnt [8] = '{default: 0};
	logic [15:0] sem_m = 0;
	logic [15:0] rd, e, w;
	logic [9:0] xr;
	logic ib;

	roc_ctl dut (.*);
	roc_far_model far (.clk_i(clk_i), .xs_rd_i(xs_rd_o), .xs_ext_i(xs_ext_o),
		.xs_state_i(xs_state_o), .xs_reg_i(xs_reg_o), .xs_data_o(xs_data_i));

	always #12.5 clk_i = ~clk_i;

	// A hang is cut short well beyond the length of the sequence
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			failures++;
			test_done();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		n_tests++;
		if (g !== x) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, x, g);
		end
	endtask

	// Word the far side returns for one file register
	function automatic logic [15:0] pf(input logic x, input logic [2:0] t, input logic [4:0] r);
		return {x, t, r, 7'h35} ^ 16'h9c00;
	endfunction

	// One instruction, entered at a falling edge; result is read two edges after issue
	task automatic op(input logic [2:0] st, input logic [15:0] ins, wd, r1, r2);
		op_valid_i = 1;
		op_state_i = st;
		op_instr_i = ins;
		op_word_i = wd;
		op_reg1_i = r1;
		op_reg2_i = r2;
		#1 xr = {xs_rd_o, xs_ext_o, xs_state_o, xs_reg_o};
		@(negedge clk_i) op_valid_i = 0;
		@(negedge clk_i);
		chk("done", 1, done_o);
	endtask

	task automatic ro(input logic wr, input logic [3:0] g, input logic [2:0] t,
		input logic [4:0] r, input logic [15:0] v);
		op(EXEC_STATE, {OPC_OPTION, wr, 7'h02}, {4'h0, g, t, r}, 16'h0, v);
		rd = wb_data_o;
	endtask

	task automatic mw(input logic [2:0] t, input logic [15:0] a, input logic x);
		mem_wr_i = 1;
		mem_wr_state_i = t;
		mem_wr_addr_i = a;
		#1 chk("wr_ok", x, mem_wr_ok_o);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hf177879b));
		repeat (5) @(negedge clk_i);
		resetn_i = 1;
		chk("sem_rst", SEM_RST, sem_o);
		mw(3'h6, 16'h1234, 1);
		// Bounds: both page edges of each protected state
		for (s = 5; s < 8; s++) begin
			b = $urandom_range(200, 1);
			e = {b[7:0] + 8'h30, b[7:0]};
			ro(1, GRP_BOUNDS, s[2:0], 5'h0, e);
			ro(0, GRP_BOUNDS, s[2:0], 5'h0, 16'h0);
			chk("bound", e, rd);
			mw(s[2:0], {e[7:0] - 8'h1, 8'hff}, 0);
			mw(s[2:0], {e[7:0], 8'h00}, 1);
			mw(s[2:0], {e[15:8], 8'hff}, 1);
			mw(s[2:0], {e[15:8] + 8'h1, 8'h00}, 0);
			mw(3'h4, {e[15:8] + 8'h1, 8'h00}, 1);
		end
		ro(1, GRP_BOUNDS, 3'h5, 5'h0, BOUND_OFF);
		mw(3'h5, 16'h0000, 1);
		mem_wr_i = 0;
		// Absent features read zero and raise nothing
		ro(1, 4'h7, 3'h1, 5'h0, 16'hbeef);
		chk("noflag", 0, invalid_o);
		ro(0, 4'h7, 3'h1, 5'h0, 16'h0);
		chk("absent", {1'b0, 16'h0}, {invalid_o, rd});
		ro(0, GRP_BOUNDS, 3'h5, 5'h1, 16'h0);
		chk("reg1", 0, rd);
		// Random grants, then each count read as two halves
		for (b = 0; b < 300; b++) begin
			s = $urandom_range(7, 0);
			grant_valid_i = 1;
			grant_state_i = s[2:0];
			cnt[s] += 1;
			@(negedge clk_i);
		end
		grant_valid_i = 0;
		ro(1, GRP_ACCT, 3'h2, 5'h0, 16'h1234);
		cnt[2] = 0;
		for (s = 0; s < 8; s++) begin
			ro(0, GRP_ACCT, s[2:0], 5'h0, 16'h0);
			w = rd;
			ro(0, GRP_ACCT, s[2:0], ACCT_WORD1, 16'h0);
			chk("acct", cnt[s], {w, rd});
		end
		// Semaphore with random bits
		for (b = 0; b < 40; b++) begin
			s = $urandom_range(15, 0);
			if ($urandom_range(2, 0) == 0) begin
				op(3'h5, {OPC_SEM_CLR, s[3:0], 4'h0}, 16'h0, 16'h0, 16'h0);
				sem_m[s] = 0;
			end else begin
				op(3'h5, {OPC_SEM_TST, s[3:0], 4'h0}, 16'h0, 16'h0, 16'h0);
				chk("adv", sem_m[s] ? ADV_FALL : ADV_TAKEN, pa_adv_o);
				sem_m[s] = 1;
			end
			chk("sem", sem_m, sem_o);
		end
		// Cross-state reads by the executive, junk in the ignored bits
		for (b = 0; b < 12; b++) begin
			s = $urandom_range(7, 0);
			e = 16'($urandom_range(31, 0));
			ib = 1'($urandom_range(1, 0));
			w = {7'($urandom_range(127, 0)), 1'b0, s[2:0], 5'h0};
			op(EXEC_STATE, {OPC_XSTATE, 1'b0, 3'h1, ib, 3'h5}, w, e, 16'h0);
			chk("xs_port", {2'b10, s[2:0], e[4:0]}, xr);
			chk("xs_data", {ib, 3'h5, pf(1'b0, s[2:0], e[4:0])},
				{wb_to_mem_o, wb_reg_o, wb_data_o});
			chk("xs_sel", w + e, xs_select_o);
		end
		op(3'h3, {OPC_XSTATE, 8'h02}, 16'h0043, 16'h0, 16'h0);
		chk("xs_state3", 1, invalid_o);
		op(EXEC_STATE, {OPC_XSTATE, 8'h02}, 16'h014c, 16'h0, 16'h0);
		chk("xs_io", 1, invalid_o);
		// Select register loaded by extended write, still no access for state 6
		op(3'h6, {OPC_XREG_WR, 4'h0, XS_SEL_REG}, 16'h0, 16'h0, 16'h01a3);
		chk("xs_wrx", 16'h01a3, xs_select_o);
		op(3'h6, {OPC_XSTATE, 8'h02}, 16'h01a3, 16'h0, 16'h0);
		chk("xs_other", 1, invalid_o);
		op(3'h7, {OPC_BRANCH, 8'h56}, 16'h0, 16'h3c5a, 16'h0);
		chk("cm", {3'h1, 16'h3c5a, 3'h6}, {invalid_o, cm_branch_o, cm_addr_o, cm_param_o});
		// Without privilege
		priv_mode_i = 8'h00;
		ro(0, GRP_BOUNDS, 3'h6, 5'h0, 16'h0);
		chk("unpriv_ro", 2'b10, {invalid_o, wb_valid_o});
		op(3'h7, {OPC_BRANCH, 8'h56}, 16'h0, 16'h3c5a, 16'h0);
		chk("unpriv_cm", 2'b10, {invalid_o, cm_branch_o});
		op(3'h6, {OPC_SEM_TST, 8'hf0}, 16'h0, 16'h0, 16'h0);
		chk("open", {1'b0, sem_m[15] ? ADV_FALL : ADV_TAKEN}, {invalid_o, pa_adv_o});
		sem_m[15] = 1;
		op(3'h6, {OPC_SEM_CLR, 8'h30}, 16'h0, 16'h0, 16'h0);
		chk("locked", {1'b1, sem_m}, {invalid_o, sem_o});
		op(3'h6, {OPC_SEM_CLR, 8'hf0}, 16'h0, 16'h0, 16'h0);
		sem_m[15] = 0;
		chk("open_clr", sem_m, sem_o);
		test_done();
	end
endmodule
